// File: hw/i2ces_pkg.sv
// Constants and carrier types for the enable, status and FIFO level block.
package i2ces_pkg;

  // ****************************************************************
  // Widths and sizes
  // ****************************************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 16;
  localparam int BYTE_W = 8;
  localparam int DEPTH  = 32;
  localparam int LVL_W  = 6;
  localparam int PTR_W  = 5;

  // ****************************************************************
  // Register offsets
  // ****************************************************************
  localparam logic [ADDR_W-1:0] OFF_CLR_ACT   = 32'h5000155C;
  localparam logic [ADDR_W-1:0] OFF_CLR_START = 32'h50001564;
  localparam logic [ADDR_W-1:0] OFF_CLR_BCAST = 32'h50001568;
  localparam logic [ADDR_W-1:0] OFF_ENABLE    = 32'h5000156C;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 32'h50001570;
  localparam logic [ADDR_W-1:0] OFF_TX_LEVEL  = 32'h50001574;
  localparam logic [ADDR_W-1:0] OFF_RX_LEVEL  = 32'h50001578;
  localparam logic [ADDR_W-1:0] OFF_RAW       = 32'h50001600;
  localparam logic [ADDR_W-1:0] OFF_INT_EN    = 32'h50001604;
  localparam logic [ADDR_W-1:0] OFF_INT_CLR   = 32'h50001608;
  localparam logic [ADDR_W-1:0] OFF_TX_DATA   = 32'h5000160C;
  localparam logic [ADDR_W-1:0] OFF_RX_DATA   = 32'h50001610;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int BIT_ENABLE   = 0;
  localparam int BIT_ACT      = 8;
  localparam int BIT_START    = 10;
  localparam int BIT_BCAST    = 11;
  localparam int ST_ANY_BUSY  = 0;
  localparam int ST_TX_SPACE  = 1;
  localparam int ST_TX_EMPTY  = 2;
  localparam int ST_RX_NEMPTY = 3;
  localparam int ST_RX_FULL   = 4;
  localparam int ST_INIT_BUSY = 5;
  localparam int ST_TGT_BUSY  = 6;

  // ****************************************************************
  // Reset values and timing
  // ****************************************************************
  localparam logic             ENABLE_RST   = 1'h0;
  localparam logic [DATA_W-1:0] INT_EN_RST  = 16'h0000;
  localparam int               ENABLE_DELAY = 2;

  // ****************************************************************
  // Carriers to and from the bus engine
  // ****************************************************************
  typedef struct packed {
    logic              initiator_fsm_busy;
    logic              target_fsm_busy;
    logic              start_seen;
    logic              broadcast_address;
    logic              tx_req;
    logic              rx_push;
    logic [BYTE_W-1:0] rx_byte;
  } i2ces_eng_in_t;

  typedef struct packed {
    logic              run;
    logic              nack;
    logic              tx_grant;
    logic [BYTE_W-1:0] tx_byte;
    logic              rx_queue_full;
  } i2ces_eng_out_t;

endpackage

// File: hw/i2ces_fifo.sv
// Byte FIFO with level count, used for both transmit and receive queues.
`timescale 1ns/1ps
`default_nettype none
module i2ces_fifo
  import i2ces_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              ce,
  // Control
  input  wire logic              flush,
  input  wire logic              push,
  input  wire logic              pop,
  // Data and level
  input  wire logic [BYTE_W-1:0] wdata,
  output logic      [BYTE_W-1:0] rdata,
  output logic      [LVL_W-1:0]  count,
  output logic                   empty,
  output logic                   full
);

  logic [BYTE_W-1:0] mem [DEPTH];
  logic [PTR_W-1:0]  wptr;
  logic [PTR_W-1:0]  rptr;

  wire do_push = push && !full && !flush;
  wire do_pop  = pop && !empty && !flush;

  assign empty = (count == '0);
  assign full  = (count == LVL_W'(DEPTH));
  assign rdata = mem[rptr];

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wptr  <= '0;
      rptr  <= '0;
      count <= '0;
    end else if (ce) begin
      wptr  <= flush ? '0 : wptr + PTR_W'(do_push);
      rptr  <= flush ? '0 : rptr + PTR_W'(do_pop);
      count <= flush ? '0 : count + LVL_W'(do_push) - LVL_W'(do_pop);
    end
  end

  always_ff @(posedge clock) begin
    if (ce && do_push) begin
      mem[wptr] <= wdata;
    end
  end

endmodule // i2ces_fifo
`default_nettype wire

// File: hw/i2ces_top.sv
// Enable, status, event flags and FIFO levels of the two-wire bus controller.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Reading start clear register clears flag 10.
// - Reading broadcast clear register clears flag 11.
// - Enable bit resets 0; disabled holds FIFOs erased.
// - Disable flushes transmit and receive FIFOs.
// - Masked flags stay active until idle.
// - Disabled transmitter finishes byte, discards queue.
// - Disabled receiver stops, does not acknowledge.
// - Enable change takes effect two cycles later.
// - Status bit 6 shows target busy.
// - Status bit 5 shows initiator busy.
// - Status bit 4 shows receive FIFO full.
// - Status bit 3 shows receive FIFO nonempty.
// - Status bit 2 shows transmit empty, no interrupt.
// - Status bit 1 shows transmit space free.
// - Transmit level register reports transmit count.
// - Receive level register reports receive count.
// - Activity flag clears only when idle.
module i2ces_top
  import i2ces_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic              clock,
  input  wire logic              resetn,
  input  wire logic              ce,
  // Register port
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [DATA_W-1:0] bus_wdata,
  input  wire logic              bus_wr,
  input  wire logic              bus_rd,
  output logic      [DATA_W-1:0] bus_rdata,
  // Bus engine
  input  wire i2ces_eng_in_t     eng_in,
  output i2ces_eng_out_t         eng_out,
  // Interrupt
  output logic                   irq
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire rd_clr_act   = bus_rd && (bus_addr == OFF_CLR_ACT);
  wire rd_clr_start = bus_rd && (bus_addr == OFF_CLR_START);
  wire rd_clr_bcast = bus_rd && (bus_addr == OFF_CLR_BCAST);
  wire rd_rx_data   = bus_rd && (bus_addr == OFF_RX_DATA);
  wire wr_enable    = bus_wr && (bus_addr == OFF_ENABLE);
  wire wr_int_en    = bus_wr && (bus_addr == OFF_INT_EN);
  wire wr_int_clr   = bus_wr && (bus_addr == OFF_INT_CLR);
  wire wr_tx_data   = bus_wr && (bus_addr == OFF_TX_DATA);

  // ****************************************************************
  // State
  // ****************************************************************
  logic                    enable_reg;
  logic [ENABLE_DELAY-1:0] en_pipe;
  logic                    nack_q;
  logic                    grant_q;
  logic [BYTE_W-1:0]       tx_byte_q;
  logic                    rx_full_q;
  logic [DATA_W-1:0]       int_en;
  logic [DATA_W-1:0]       raw;
  logic [2:0]              flag_q;
  logic [DATA_W-1:0]       next_rdata;
  logic [BYTE_W-1:0]       tx_head;
  logic [BYTE_W-1:0]       rx_head;
  logic [LVL_W-1:0]        tx_cnt;
  logic [LVL_W-1:0]        rx_cnt;
  logic                    tx_empty;
  logic                    tx_full;
  logic                    rx_empty;
  logic                    rx_full;

  wire enable_eff = en_pipe[ENABLE_DELAY-1];
  wire busy_any   = eng_in.initiator_fsm_busy || eng_in.target_fsm_busy;
  wire [DATA_W-1:0] masked = raw & int_en;
  wire any_masked = |masked;

  // ****************************************************************
  // Enable and its delay
  // ****************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      enable_reg <= ENABLE_RST;
    end else if (ce && wr_enable) begin
      enable_reg <= bus_wdata[BIT_ENABLE];
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en_pipe <= '0;
      nack_q  <= 1'b1;
    end else if (ce) begin
      en_pipe <= {en_pipe[ENABLE_DELAY-2:0], enable_reg};
      nack_q  <= !en_pipe[ENABLE_DELAY-2];
    end
  end

  // ****************************************************************
  // Queues
  // ****************************************************************
  // no grant disabled
  wire tx_take = eng_in.tx_req && enable_eff && !tx_empty;

  i2ces_fifo u_tx_fifo (
    .clock  (clock),
    .resetn (resetn),
    .ce     (ce),
    .flush  (!enable_eff),
    .push   (wr_tx_data),
    .pop    (tx_take),
    .wdata  (bus_wdata[BYTE_W-1:0]),
    .rdata  (tx_head),
    .count  (tx_cnt),
    .empty  (tx_empty),
    .full   (tx_full)
  );

  i2ces_fifo u_rx_fifo (
    .clock  (clock),
    .resetn (resetn),
    .ce     (ce),
    .flush  (!enable_eff),
    .push   (eng_in.rx_push),
    .pop    (rd_rx_data),
    .wdata  (eng_in.rx_byte),
    .rdata  (rx_head),
    .count  (rx_cnt),
    .empty  (rx_empty),
    .full   (rx_full)
  );

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      grant_q   <= 1'b0;
      tx_byte_q <= '0;
      rx_full_q <= 1'b0;
    end else if (ce) begin
      grant_q   <= tx_take;
      tx_byte_q <= tx_take ? tx_head : tx_byte_q;
      rx_full_q <= rx_full;
    end
  end

  assign eng_out = '{run: enable_eff, nack: nack_q, tx_grant: grant_q,
                     tx_byte: tx_byte_q, rx_queue_full: rx_full_q};

  // ****************************************************************
  // Event flags
  // ****************************************************************
  localparam int FLAG_POS [3] = '{BIT_ACT, BIT_START, BIT_BCAST};
  wire [2:0] flag_set = {eng_in.broadcast_address, eng_in.start_seen, busy_any};
  wire act_clr = !busy_any && (rd_clr_act || !enable_eff);
  wire [2:0] flag_clr = {rd_clr_bcast, rd_clr_start, act_clr};

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_flag
      always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
          flag_q[g] <= 1'b0;
        end else if (ce) begin
          flag_q[g] <= flag_set[g] ||
                       (flag_q[g] && !flag_clr[g] &&
                        !(wr_int_clr && bus_wdata[FLAG_POS[g]]));
        end
      end
      assign raw[FLAG_POS[g]] = flag_q[g];
    end
  endgenerate

  assign raw[7:0]              = '0;
  assign raw[9]                = 1'b0;
  assign raw[DATA_W-1:12]      = '0;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      int_en <= INT_EN_RST;
      irq    <= 1'b0;
    end else if (ce) begin
      int_en <= wr_int_en ? bus_wdata : int_en;
      irq    <= any_masked;
    end
  end

  // ****************************************************************
  // Read data
  // ****************************************************************
  // status bits
  wire [DATA_W-1:0] status_word = {
    9'h000,
    eng_in.target_fsm_busy,
    eng_in.initiator_fsm_busy,
    rx_full,
    !rx_empty,
    tx_empty,
    !tx_full,
    busy_any
  };

  always_comb begin
    next_rdata = '0;
    unique case (bus_addr)
      OFF_CLR_ACT:   next_rdata = DATA_W'(raw[BIT_ACT]);
      OFF_CLR_START: next_rdata = DATA_W'(raw[BIT_START]);
      OFF_CLR_BCAST: next_rdata = DATA_W'(raw[BIT_BCAST]);
      OFF_ENABLE:    next_rdata = DATA_W'(enable_reg);
      OFF_STATUS:    next_rdata = status_word;
      OFF_TX_LEVEL:  next_rdata = DATA_W'(tx_cnt);
      OFF_RX_LEVEL:  next_rdata = DATA_W'(rx_cnt);
      OFF_RAW:       next_rdata = raw;
      OFF_INT_EN:    next_rdata = int_en;
      OFF_RX_DATA:   next_rdata = DATA_W'(rx_head);
      default:       next_rdata = '0;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bus_rdata <= '0;
    end else if (ce) begin
      bus_rdata <= bus_rd ? next_rdata : '0;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn || !ce);

  wire rd_status = bus_rd && (bus_addr == OFF_STATUS);

  start_clear_a: assert property (rd_clr_start && !eng_in.start_seen |=> !raw[BIT_START])
    else $error("start flag not cleared by read");
  bcast_clear_a: assert property (rd_clr_bcast && !eng_in.broadcast_address
                                  |=> !raw[BIT_BCAST])
    else $error("broadcast flag not cleared by read");
  held_erased_a: assert property (!enable_eff ##1 !enable_eff
                                  |-> rx_cnt == '0 && tx_cnt == '0)
    else $error("queues not erased while disabled");
  flush_tx_a: assert property ($fell(enable_eff) |=> tx_cnt == '0 && rx_cnt == '0)
    else $error("queues not flushed on disable");
  masked_hold_a: assert property (!enable_eff && busy_any && masked != '0
                                  |=> irq && raw[BIT_ACT])
    else $error("masked flag dropped while busy");
  tx_stop_a: assert property (!enable_eff |=> !eng_out.tx_grant)
    else $error("transmit byte granted while disabled");
  rx_nack_a: assert property (!enable_eff |-> eng_out.nack)
    else $error("acknowledge allowed while disabled");
  en_delay_a: assert property ($past(ce) && $past(ce, 2) |->
                               enable_eff == $past(enable_reg, 2))
    else $error("enable not applied two cycles after write");
  tgt_busy_a: assert property (rd_status |=> bus_rdata[ST_TGT_BUSY] ==
                               $past(eng_in.target_fsm_busy))
    else $error("target busy bit wrong");
  init_busy_a: assert property (rd_status |=> bus_rdata[ST_INIT_BUSY] ==
                                $past(eng_in.initiator_fsm_busy))
    else $error("initiator busy bit wrong");
  rx_full_a: assert property (rd_status |=> bus_rdata[ST_RX_FULL] ==
                              ($past(rx_cnt) == LVL_W'(DEPTH)))
    else $error("receive full bit wrong");
  rx_nempty_a: assert property (rd_status |=> bus_rdata[ST_RX_NEMPTY] ==
                                ($past(rx_cnt) != '0))
    else $error("receive nonempty bit wrong");
  tx_empty_a: assert property (rd_status |=> bus_rdata[ST_TX_EMPTY] ==
                               ($past(tx_cnt) == '0))
    else $error("transmit empty bit wrong");
  tx_space_a: assert property (rd_status |=> bus_rdata[ST_TX_SPACE] ==
                               ($past(tx_cnt) != LVL_W'(DEPTH)))
    else $error("transmit space bit wrong");
  tx_level_a: assert property (bus_rd && bus_addr == OFF_TX_LEVEL
                               |=> bus_rdata == DATA_W'($past(tx_cnt)))
    else $error("transmit level wrong");
  rx_level_a: assert property (bus_rd && bus_addr == OFF_RX_LEVEL
                               |=> bus_rdata == DATA_W'($past(rx_cnt)))
    else $error("receive level wrong");
  any_busy_a: assert property (rd_status |=> bus_rdata[ST_ANY_BUSY] ==
                               $past(busy_any))
    else $error("activity bit wrong");
  act_keep_a: assert property (rd_clr_act && busy_any |=> raw[BIT_ACT])
    else $error("activity flag cleared while busy");
  act_auto_a: assert property (!enable_eff && !busy_any |=> !raw[BIT_ACT])
    else $error("activity flag not auto cleared");
  act_read_a: assert property (rd_clr_act && !busy_any |=> !raw[BIT_ACT])
    else $error("activity flag not cleared by idle read");
  start_set_a: assert property (eng_in.start_seen |=> raw[BIT_START])
    else $error("start flag not set by event");
  en_set_a: assert property (wr_enable && bus_wdata[BIT_ENABLE] |=> enable_reg)
    else $error("enable bit not set by write");
  en_clear_a: assert property (wr_enable && !bus_wdata[BIT_ENABLE] |=> !enable_reg)
    else $error("enable bit not cleared by write");
  rx_ack_a: assert property (enable_eff |-> !eng_out.nack)
    else $error("acknowledge refused while enabled");
  tx_grant_a: assert property (eng_in.tx_req && enable_eff && !tx_empty |=> eng_out.tx_grant &&
                               eng_out.tx_byte == $past(tx_head))
    else $error("transmit byte not granted");
  irq_source_a: assert property ($past(ce) |-> irq == $past(any_masked))
    else $error("interrupt not following enabled flags");

  start_read_c: cover property (raw[BIT_START] ##1 rd_clr_start ##1 !raw[BIT_START]);
  disable_busy_c: cover property ($fell(enable_eff) && busy_any);
  rx_full_c: cover property (rx_full);
  tx_grant_c: cover property (eng_out.tx_grant);
  act_auto_c: cover property (raw[BIT_ACT] && !enable_eff ##1 !raw[BIT_ACT]);

endmodule // i2ces_top
`default_nettype wire

// File: test/i2ces_engine_model.sv
// Behavioural model of the bus engine that faces the controller.
`timescale 1ns/1ps
`default_nettype none
module i2ces_engine_model
  import i2ces_pkg::*;
(
  // Clock
  input  wire logic           clock,
  // Engine link
  input  wire i2ces_eng_out_t eng_out,
  output var  i2ces_eng_in_t  eng_in
);
  // ****************************************************************
  // Engine actions, each launched just after a rising edge
  // ****************************************************************
  initial eng_in = '0;

  // Busy levels of both state machines.
  task automatic set_busy(input logic ib, input logic tb);
    @(posedge clock);
    eng_in.initiator_fsm_busy <= ib;
    eng_in.target_fsm_busy    <= tb;
  endtask

  // One-cycle start and broadcast events.
  task automatic pulse_event(input logic st, input logic bc);
    @(posedge clock);
    eng_in.start_seen        <= st;
    eng_in.broadcast_address <= bc;
    @(posedge clock);
    eng_in.start_seen        <= 1'b0;
    eng_in.broadcast_address <= 1'b0;
  endtask

  // Asks for one byte after an idle gap and takes the answer one cycle later.
  task automatic ask_byte(input int gap, output logic granted, output logic [BYTE_W-1:0] b);
    repeat (gap) @(posedge clock);
    @(posedge clock);
    eng_in.tx_req <= 1'b1;
    @(posedge clock);
    eng_in.tx_req <= 1'b0;
    #1;
    granted = eng_out.tx_grant;
    b = eng_out.tx_byte;
  endtask

  // Hands over one received byte; the data lines show junk afterwards.
  task automatic push_byte(input logic [BYTE_W-1:0] b);
    @(posedge clock);
    eng_in.rx_push <= 1'b1;
    eng_in.rx_byte <= b;
    @(posedge clock);
    eng_in.rx_push <= 1'b0;
    eng_in.rx_byte <= ~b;
  endtask
endmodule // i2ces_engine_model
`default_nettype wire

// File: test/tb_i2c_enable_status_fifo_level.sv
// Self-checking testbench of the enable, status and FIFO level block.
`timescale 1ns/1ps
`default_nettype none
module tb_i2c_enable_status_fifo_level
  import i2ces_pkg::*;
;
  logic              clock     = 1'b0;
  logic              resetn    = 1'b0;
  logic              ce        = 1'b1;
  logic [ADDR_W-1:0] bus_addr  = '0;
  logic [DATA_W-1:0] bus_wdata = '0;
  logic              bus_wr    = 1'b0;
  logic              bus_rd    = 1'b0;
  logic [DATA_W-1:0] bus_rdata;
  i2ces_eng_in_t     eng_in;
  i2ces_eng_out_t    eng_out;
  logic              irq;
  int                num_errors = 0;
  int                cmp_count  = 0;
  int                cycles     = 0;
  int                seed       = 99657;

  always #25 clock = ~clock;

  i2ces_top dut (
    .clock     (clock),
    .resetn    (resetn),
    .ce        (ce),
    .bus_addr  (bus_addr),
    .bus_wdata (bus_wdata),
    .bus_wr    (bus_wr),
    .bus_rd    (bus_rd),
    .bus_rdata (bus_rdata),
    .eng_in    (eng_in),
    .eng_out   (eng_out),
    .irq       (irq)
  );
  i2ces_engine_model partner (
    .clock   (clock),
    .eng_out (eng_out),
    .eng_in  (eng_in)
  );

  // ****************************************************************
  // Bus tasks, compares and expectations
  // ****************************************************************
  task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    bus_wr    <= 1'b1;
    bus_addr  <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~d;
  endtask

  task automatic reg_read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    bus_rd   <= 1'b1;
    bus_addr <= a;
    @(posedge clock);
    bus_rd   <= 1'b0;
    bus_addr <= ~a;
    #1;
    d = bus_rdata;
  endtask

  task automatic check(input string name, input logic [DATA_W-1:0] exp,
                       input logic [DATA_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic check_reg(input string name, input logic [ADDR_W-1:0] a,
                           input logic [DATA_W-1:0] exp);
    logic [DATA_W-1:0] d;
    reg_read(a, d);
    check(name, exp, d);
  endtask

  function automatic logic [DATA_W-1:0] exp_status(int txn, int rxn, logic ib, logic tb);
    logic [DATA_W-1:0] s;
    s = '0;
    s[ST_ANY_BUSY]  = ib | tb;
    s[ST_TX_SPACE]  = (txn < DEPTH);
    s[ST_TX_EMPTY]  = (txn == 0);
    s[ST_RX_NEMPTY] = (rxn != 0);
    s[ST_RX_FULL]   = (rxn == DEPTH);
    s[ST_INIT_BUSY] = ib;
    s[ST_TGT_BUSY]  = tb;
    return s;
  endfunction

  function automatic logic [DATA_W-1:0] exp_raw(logic act, logic st, logic bc);
    logic [DATA_W-1:0] r;
    r = '0;
    r[BIT_ACT]   = act;
    r[BIT_START] = st;
    r[BIT_BCAST] = bc;
    return r;
  endfunction

  task automatic complete_run();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 6000) begin
      num_errors++;
      complete_run();
    end
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [DATA_W-1:0] d;
    logic [BYTE_W-1:0] b;
    logic              g;
    logic [BYTE_W-1:0] q[$];
    repeat (4) @(posedge clock);
    resetn <= 1'b1;
    check_reg("status", OFF_STATUS, exp_status(0, 0, 0, 0));
    check_reg("tx level", OFF_TX_LEVEL, 16'h0000);
    check_reg("rx level", OFF_RX_LEVEL, 16'h0000);
    check_reg("enable", OFF_ENABLE, 16'h0000);
    reg_write(OFF_TX_DATA, 16'h00A5);
    check_reg("tx level", OFF_TX_LEVEL, 16'h0000);
    reg_write(OFF_ENABLE, 16'h0001);
    #1;
    check("run", 16'h0000, {15'h0000, eng_out.run});
    repeat (2) @(posedge clock);
    #1;
    check("run", 16'h0001, {15'h0000, eng_out.run});
    check("nack", 16'h0000, {15'h0000, eng_out.nack});
    // Clock enable low: a write is ignored.
    @(posedge clock);
    ce <= 1'b0;
    reg_write(OFF_TX_DATA, 16'h00C3);
    ce <= 1'b1;
    check_reg("tx level", OFF_TX_LEVEL, 16'h0000);
    // Transmit queue filled to the brim, then drained by the engine.
    for (int i = 0; i < DEPTH; i++) begin
      b = BYTE_W'($random(seed));
      q.push_back(b);
      reg_write(OFF_TX_DATA, {8'h00, b});
      check_reg("tx level", OFF_TX_LEVEL, 16'(i + 1));
    end
    check_reg("status", OFF_STATUS, exp_status(DEPTH, 0, 0, 0));
    reg_write(OFF_TX_DATA, 16'h005A);
    check_reg("tx level", OFF_TX_LEVEL, 16'(DEPTH));
    partner.set_busy(1'b1, 1'b0);
    for (int i = 0; i < DEPTH; i++) begin
      partner.ask_byte($unsigned($random(seed)) % 4, g, b);
      check("grant", 16'h0001, {15'h0000, g});
      check("tx byte", {8'h00, q.pop_front()}, {8'h00, b});
    end
    check_reg("status", OFF_STATUS, exp_status(0, 0, 1, 0));
    partner.set_busy(1'b0, 1'b1);
    check_reg("status", OFF_STATUS, exp_status(0, 0, 0, 1));
    // Activity flag survives a clear while busy, then clears when idle.
    reg_read(OFF_CLR_ACT, d);
    check_reg("raw", OFF_RAW, exp_raw(1, 0, 0));
    partner.set_busy(1'b0, 1'b0);
    repeat (2) @(posedge clock);
    reg_read(OFF_CLR_ACT, d);
    check("act clear", 16'h0001, d);
    check_reg("raw", OFF_RAW, exp_raw(0, 0, 0));
    // Start and broadcast events, interrupt raised, cleared by reads, masked.
    partner.pulse_event(1'b1, 1'b0);
    partner.pulse_event(1'b0, 1'b1);
    check_reg("raw", OFF_RAW, exp_raw(0, 1, 1));
    reg_write(OFF_INT_EN, 16'h0C00);
    repeat (2) @(posedge clock);
    #1;
    check("irq", 16'h0001, {15'h0000, irq});
    reg_read(OFF_CLR_START, d);
    check("start clear", 16'h0001, d);
    check_reg("raw", OFF_RAW, exp_raw(0, 0, 1));
    reg_read(OFF_CLR_BCAST, d);
    check("bcast clear", 16'h0001, d);
    check_reg("raw", OFF_RAW, exp_raw(0, 0, 0));
    #1;
    check("irq", 16'h0000, {15'h0000, irq});
    reg_write(OFF_INT_EN, 16'h0000);
    partner.pulse_event(1'b1, 1'b0);
    repeat (2) @(posedge clock);
    #1;
    check("irq", 16'h0000, {15'h0000, irq});
    reg_write(OFF_INT_CLR, 16'h0400);
    check_reg("raw", OFF_RAW, exp_raw(0, 0, 0));
    // Receive queue filled until it refuses, then two bytes read back.
    for (int i = 0; i < DEPTH; i++) begin
      b = BYTE_W'($random(seed));
      q.push_back(b);
      partner.push_byte(b);
      check_reg("rx level", OFF_RX_LEVEL, 16'(i + 1));
    end
    partner.push_byte(8'hC3);
    check_reg("status", OFF_STATUS, exp_status(0, DEPTH, 0, 0));
    check("rx full", 16'h0001, {15'h0000, eng_out.rx_queue_full});
    check_reg("rx level", OFF_RX_LEVEL, 16'(DEPTH));
    for (int i = 0; i < 2; i++) begin
      check_reg("rx byte", OFF_RX_DATA, {8'h00, q.pop_front()});
    end
    check_reg("status", OFF_STATUS, exp_status(0, DEPTH - 2, 0, 0));
    // Disable with both queues holding data and the target still busy.
    for (int i = 0; i < 3; i++) begin
      reg_write(OFF_TX_DATA, 16'(i + 1));
    end
    reg_write(OFF_INT_EN, 16'h0100);
    partner.set_busy(1'b0, 1'b1);
    reg_write(OFF_ENABLE, 16'h0000);
    @(posedge clock);
    #1;
    check("run", 16'h0001, {15'h0000, eng_out.run});
    @(posedge clock);
    #1;
    check("run", 16'h0000, {15'h0000, eng_out.run});
    repeat (4) @(posedge clock);
    #1;
    check("nack", 16'h0001, {15'h0000, eng_out.nack});
    check("irq", 16'h0001, {15'h0000, irq});
    check_reg("tx level", OFF_TX_LEVEL, 16'h0000);
    check_reg("rx level", OFF_RX_LEVEL, 16'h0000);
    check_reg("status", OFF_STATUS, exp_status(0, 0, 0, 1));
    partner.ask_byte(0, g, b);
    check("grant", 16'h0000, {15'h0000, g});
    check_reg("raw", OFF_RAW, exp_raw(1, 0, 0));
    partner.set_busy(1'b0, 1'b0);
    repeat (3) @(posedge clock);
    #1;
    check("irq", 16'h0000, {15'h0000, irq});
    check_reg("raw", OFF_RAW, exp_raw(0, 0, 0));
    reg_write(OFF_INT_EN, 16'hFFFF);
    repeat (2) @(posedge clock);
    #1;
    check("irq", 16'h0000, {15'h0000, irq});
    complete_run();
  end
endmodule // tb_i2c_enable_status_fifo_level
`default_nettype wire
